// file: bench/dnvm_monitor.sv
/* Port checker of the access sequencer.
   Assumes it is bound to dnvm_sequencer, one clock, reset synchronous. */
`timescale 1ns/1ps
`default_nettype none
module dnvm_monitor (
   input wire core_clk,
   input wire reset,
   input wire addr_low_we,
   input wire addr_up_we,
   input wire data_we,
   input wire ctrl_we,
   input wire [7:0] ctrl_wdata,
   input wire irq_ack,
   input wire [7:0] nv_addr_low_byte,
   input wire nv_addr_upper_bit,
   input wire [7:0] nv_data_byte,
   input wire [7:0] nv_control,
   input wire nv_done_flag,
   input wire busy
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   wire take = ctrl_we && !busy;
   read_start_a: assert property (take && {ctrl_wdata[5], ctrl_wdata[3:0]} == 5'h03
      && nv_control[1] && !nv_control[0]
      |=> busy && nv_control[0] ##2 !busy && !nv_control[0])
      else $error("read start");
   read_refused_a: assert property (take && !ctrl_wdata[1] |=> !nv_control[0])
      else $error("read refused");
   write_refused_a: assert property (take && !ctrl_wdata[3] |=> !nv_control[2])
      else $error("write refused");
   data_hold_a: assert property (!busy && !data_we |=> $stable(nv_data_byte))
      else $error("data hold");
   page_field_a: assert property (!addr_low_we
      |=> nv_addr_low_byte[7:4] == $past(nv_addr_low_byte[7:4]))
      else $error("page field");
   offset_sat_a: assert property (nv_addr_low_byte[3:0] == 4'hf && !addr_low_we
      |=> nv_addr_low_byte[3:0] == 4'hf)
      else $error("offset sat");
   erase_end_a: assert property ($fell(nv_control[5]) && !$past(ctrl_we)
      |-> !nv_control[6] && nv_done_flag)
      else $error("erase end");
   done_ack_a: assert property (irq_ack && !busy |=> !nv_done_flag)
      else $error("done ack");
   done_hold_a: assert property (nv_done_flag && !irq_ack |=> nv_done_flag)
      else $error("done hold");
   cover property (take && ctrl_wdata[5]);
   cover property ($fell(nv_control[2]));
   cover property (nv_addr_low_byte[3:0] == 4'hf && data_we);
endmodule // dnvm_monitor
bind dnvm_sequencer dnvm_monitor u_mon (.core_clk, .reset, .addr_low_we, .addr_up_we, .data_we,
   .ctrl_we, .ctrl_wdata, .irq_ack, .nv_addr_low_byte, .nv_addr_upper_bit, .nv_data_byte,
   .nv_control, .nv_done_flag, .busy);
`default_nettype wire

// file: bench/tb_top.sv
/* Self-checking bench: byte write and read, refusals, page erase, page read.
   Assumes the port checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   reg core_clk = 0;
   reg reset = 1;
   reg aw = 0, dw = 0, cw = 0, ack = 0;
   reg [8:0] v = 9'h000;
   wire [7:0] lo, dat, ctl;
   wire up, done, busy;
   integer failures = 0, check_count = 0, seed = 76671, cyc = 0, i;
   reg [7:0] val [0:3];
   reg [4:0] pg;
   dnvm_sequencer #(.T_WIPE_LO(40), .T_WIPE_HI(50), .T_WR_LO(20), .T_WR_HI(30)) u_dut (
      .core_clk(core_clk), .reset(reset), .addr_low_we(aw), .addr_low_wdata(v[7:0]),
      .addr_up_we(aw), .addr_up_wdata(v[8]), .data_we(dw), .data_wdata(v[7:0]), .ctrl_we(cw),
      .ctrl_wdata(v[7:0]), .irq_ack(ack), .nv_addr_low_byte(lo), .nv_addr_upper_bit(up),
      .nv_data_byte(dat), .nv_control(ctl), .nv_done_flag(done), .busy(busy));
   initial forever #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         summarize;
      end
   end
   task summarize;
      begin
         $display("checks %0d failures %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task chk(input [63:0] name, input [8:0] got, input [8:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   // Kind 0 address, 1 data, 2 control, 3 acknowledge; then waits while busy.
   task wr(input integer k, input [8:0] d);
      integer j;
      begin
         @(negedge core_clk);
         v = d;
         {aw, dw, cw, ack} = {k == 0, k == 1, k == 2, k == 3};
         @(negedge core_clk);
         {aw, dw, cw, ack} = 4'h0;
         for (j = 0; j < 200 && busy !== 1'b0; j = j + 1)
            @(negedge core_clk);
      end
   endtask
   // Permit write, then go in the very next cycle, then wait while busy.
   task arm(input [8:0] p, input [8:0] g);
      integer j;
      begin
         @(negedge core_clk);
         v = p;
         cw = 1'b1;
         @(negedge core_clk);
         v = p | g;
         @(negedge core_clk);
         cw = 1'b0;
         for (j = 0; j < 200 && busy !== 1'b0; j = j + 1)
            @(negedge core_clk);
      end
   endtask
   function [3:0] ofs(input integer n);
      ofs = (13 + n > 15) ? 4'hf : 13 + n;
   endfunction
   initial begin
      repeat (3) @(negedge core_clk);
      reset = 0;
      pg = $random(seed);
      for (i = 0; i < 4; i = i + 1) begin
         val[i] = $random(seed) | 8'h01;
         wr(0, {pg, 4'hc + i[3:0]});
         wr(1, val[i]);
         arm($random(seed) & 8'h80 | 8'h08, 9'h004);
         chk("wdone", {done, ctl[3:2]}, 3'b100);
         wr(3, 0);
         chk("ack", done, 1'b0);
         wr(2, 8'h02);
         wr(2, 8'h03);
         chk("rdata", dat, val[i]);
      end
      wr(2, 8'h00);
      wr(2, 8'h05);
      chk("refuse", {busy, ctl[2], ctl[0], dat}, {3'b000, val[3]});
      wr(0, {pg, 4'hd});
      wr(2, 8'h10);
      for (i = 0; i < 4; i = i + 1)
         wr(1, $random(seed));
      chk("tagadr", {up, lo}, {pg, 4'hf});
      arm(9'h050, 9'h020);
      chk("edone", {done, ctl[6:5]}, 3'b100);
      wr(3, 0);
      wr(0, {pg, 4'hc});
      wr(2, 8'h12);
      for (i = 0; i < 5; i = i + 1) begin
         wr(2, 8'h13);
         chk("pdata", dat, (i == 0) ? val[0] : 8'h00);
         chk("padr", {up, lo}, {pg, ofs(i)});
      end
      summarize;
   end
endmodule // tb_top
`default_nettype wire

// file: design/dnvm_sequencer.v
/*
 Data non-volatile memory access sequencer: byte and page reads, page erase with
 address tagging, byte write with automatic pre-erase. Control bits are plain ports.
 Assumes the CPU side pulses a write strobe per register write, on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dnvm_defs.vh"
// Overview of operation
// - Byte mode read starts at the held address when fetch_go set with fetch_permit.
// - Setting fetch_go without fetch_permit is ignored in every mode.
// - Read end clears fetch_go and loads the fetched byte into the data register.
// - The data register keeps a fetched byte until another read or write.
// - Page read advances the offset by one after each byte, holding at 0fh.
// - In page read, setting fetch_go again reads the next address.
// - Upper five address bits select the page, lower four the offset.
// - Page modes increment only the offset, saturating at 0fh.
// - Page erase clears only locations tagged by data register writes.
// - Tag buffer clears at reset and on wipe_permit falling, not rising.
// - Data register write in page mode tags address then advances offset.
// - Erase is timed by an internal timer independent of bus timing.
// - Erase end clears wipe_go by hardware.
// - Erase end clears wipe_permit by hardware.
// - Erased bytes read back as zero.
// - Byte mode write stores data register when program_go set with program_permit.
// - program_go without program_permit starts no write.
// - Write end clears program_go and program_permit in the same cycle.
// - Erase or write end sets nv_done_flag until serviced.
// - A byte write first erases the target byte.
module dnvm_sequencer #(
   parameter T_WIPE_LO = `DNVM_CYC(`DNVM_T_WIPE_LO_US),
   parameter T_WIPE_HI = `DNVM_CYC(`DNVM_T_WIPE_HI_US),
   parameter T_WR_LO = `DNVM_CYC(`DNVM_T_WR_LO_US),
   parameter T_WR_HI = `DNVM_CYC(`DNVM_T_WR_HI_US)
) (
   input wire core_clk,
   input wire reset,
   input wire addr_low_we,
   input wire [7:0] addr_low_wdata,
   input wire addr_up_we,
   input wire addr_up_wdata,
   input wire data_we,
   input wire [7:0] data_wdata,
   input wire ctrl_we,
   input wire [7:0] ctrl_wdata,
   input wire irq_ack,
   output reg [7:0] nv_addr_low_byte,
   output reg nv_addr_upper_bit,
   output reg [7:0] nv_data_byte,
   output reg [7:0] nv_control,
   output reg nv_done_flag,
   output reg busy
);
   localparam S_IDLE = 2'b00;
   localparam S_READ = 2'b01;
   localparam S_ERASE = 2'b10;
   localparam S_WRITE = 2'b11;

   reg [7:0] mem [0:`DNVM_DEPTH-1];
   reg [7:0] rdata_q;
   reg [`DNVM_PAGE-1:0] tag_q;
   reg [`DNVM_PAGE-1:0] tag_d;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [31:0] tmr_q;
   reg [31:0] tmr_d;
   reg [1:0] rcnt_q;
   reg [1:0] rcnt_d;
   reg [8:0] addr_d;
   reg [7:0] data_d;
   reg [7:0] ctrl_d;
   reg done_d;
   reg busy_d;
   integer i;

   // Page-mode address step: only the offset moves, and it sticks at the last slot.
   function [8:0] bump;
      input [8:0] a;
      begin
         if (a[3:0] == `DNVM_OFS_MAX)
            bump = a;
         else
            bump = {a[8:4], a[3:0] + 4'h1};
      end
   endfunction

   // A go bit starts an operation only on its rising write with the permit held.
   function arm_ok;
      input old_go;
      input new_go;
      input old_pm;
      input new_pm;
      begin
         arm_ok = new_go && !old_go && old_pm && new_pm;
      end
   endfunction

   // Cycle count of a timed operation, picked by the timing select bit.
   function [31:0] pick_cyc;
      input sel;
      input [31:0] lo;
      input [31:0] hi;
      begin
         if (sel)
            pick_cyc = hi;
         else
            pick_cyc = lo;
      end
   endfunction

   wire [8:0] addr;
   wire [8:0] addr_next;
   wire page_mode;
   wire tsel;
   wire idle;
   wire ctrl_take;
   wire start_rd;
   wire start_er;
   wire start_wr;
   wire [31:0] t_wipe;
   wire [31:0] t_prog;
   wire tmr_done;
   wire rd_end;
   wire er_end;
   wire wr_end;
   wire wipe_pm_fall;

   assign addr = {nv_addr_upper_bit, nv_addr_low_byte};
   assign addr_next = bump(addr);
   assign page_mode = nv_control[`DNVM_B_MODE];
   assign tsel = nv_control[`DNVM_B_TSEL];
   assign idle = (state_q == S_IDLE);
   // While an operation runs every register write is dropped.
   assign ctrl_take = idle && ctrl_we;
   assign start_rd = ctrl_take && arm_ok(nv_control[`DNVM_B_GO_F],
      ctrl_wdata[`DNVM_B_GO_F], nv_control[`DNVM_B_PM_F], ctrl_wdata[`DNVM_B_PM_F]);
   assign start_er = ctrl_take && page_mode && arm_ok(nv_control[`DNVM_B_GO_W],
      ctrl_wdata[`DNVM_B_GO_W], nv_control[`DNVM_B_PM_W], ctrl_wdata[`DNVM_B_PM_W]);
   assign start_wr = ctrl_take && !page_mode && arm_ok(nv_control[`DNVM_B_GO_P],
      ctrl_wdata[`DNVM_B_GO_P], nv_control[`DNVM_B_PM_P], ctrl_wdata[`DNVM_B_PM_P]);
   assign t_wipe = pick_cyc(tsel, T_WIPE_LO, T_WIPE_HI);
   assign t_prog = pick_cyc(tsel, T_WR_LO, T_WR_HI);
   assign tmr_done = (tmr_q == `DNVM_TMR_LAST);
   assign rd_end = (state_q == S_READ) && (rcnt_q == `DNVM_READ_LAST);
   assign er_end = (state_q == S_ERASE) && tmr_done;
   assign wr_end = (state_q == S_WRITE) && tmr_done;
   assign wipe_pm_fall = ctrl_take && nv_control[`DNVM_B_PM_W] && !ctrl_wdata[`DNVM_B_PM_W];

   // Array access, kept free of reset so it maps to a memory.
   always @(posedge core_clk) begin
      rdata_q <= mem[addr];
      if (er_end) begin
         for (i = 0; i < `DNVM_PAGE; i = i + 1) begin
            if (tag_q[i])
               mem[{addr[8:4], i[3:0]}] <= `DNVM_ERASED;
         end
      end
      // The overwrite stands in for the pre-erase of the target byte.
      if (wr_end)
         mem[addr] <= nv_data_byte;
   end

   always @* begin
      addr_d = addr;
      data_d = nv_data_byte;
      ctrl_d = nv_control;
      tag_d = tag_q;
      done_d = nv_done_flag;
      state_d = state_q;
      busy_d = busy;
      tmr_d = tmr_q;
      rcnt_d = rcnt_q;
      if (idle && addr_low_we)
         addr_d[7:0] = addr_low_wdata;
      if (idle && addr_up_we)
         addr_d[8] = addr_up_wdata;
      if (idle && data_we) begin
         data_d = data_wdata;
         if (page_mode) begin
            tag_d[addr[3:0]] = 1'b1;
            addr_d = addr_next;
         end
      end
      if (ctrl_take) begin
         ctrl_d = ctrl_wdata;
         ctrl_d[`DNVM_B_GO_F] = start_rd;
         ctrl_d[`DNVM_B_GO_P] = start_wr;
         ctrl_d[`DNVM_B_GO_W] = start_er;
      end
      // Dropping the erase permit throws the tags away; raising it keeps them.
      if (wipe_pm_fall)
         tag_d = {`DNVM_PAGE{1'b0}};
      if (irq_ack)
         done_d = 1'b0;
      case (state_q)
         S_IDLE: begin
            if (start_rd) begin
               state_d = S_READ;
               busy_d = 1'b1;
               rcnt_d = `DNVM_READ_CYC;
            end else if (start_er) begin
               state_d = S_ERASE;
               busy_d = 1'b1;
               tmr_d = t_wipe;
            end else if (start_wr) begin
               state_d = S_WRITE;
               busy_d = 1'b1;
               tmr_d = t_prog;
            end
         end
         S_READ: begin
            rcnt_d = rcnt_q - `DNVM_READ_STEP;
            if (rd_end) begin
               data_d = rdata_q;
               ctrl_d[`DNVM_B_GO_F] = 1'b0;
               if (page_mode)
                  addr_d = addr_next;
               state_d = S_IDLE;
               busy_d = 1'b0;
            end
         end
         S_ERASE: begin
            tmr_d = tmr_q - `DNVM_TMR_STEP;
            if (er_end) begin
               ctrl_d[`DNVM_B_GO_W] = 1'b0;
               ctrl_d[`DNVM_B_PM_W] = 1'b0;
               tag_d = {`DNVM_PAGE{1'b0}};
               done_d = 1'b1;
               state_d = S_IDLE;
               busy_d = 1'b0;
            end
         end
         S_WRITE: begin
            tmr_d = tmr_q - `DNVM_TMR_STEP;
            if (wr_end) begin
               ctrl_d[`DNVM_B_GO_P] = 1'b0;
               ctrl_d[`DNVM_B_PM_P] = 1'b0;
               done_d = 1'b1;
               state_d = S_IDLE;
               busy_d = 1'b0;
            end
         end
         default: begin
            state_d = S_IDLE;
            busy_d = 1'b0;
         end
      endcase
   end

   // Address pair.
   always @(posedge core_clk) begin
      if (reset) begin
         nv_addr_low_byte <= `DNVM_RST_BYTE;
         nv_addr_upper_bit <= `DNVM_RST_BIT;
      end else begin
         nv_addr_low_byte <= addr_d[7:0];
         nv_addr_upper_bit <= addr_d[8];
      end
   end

   // Data and control registers.
   always @(posedge core_clk) begin
      if (reset) begin
         nv_data_byte <= `DNVM_RST_BYTE;
         nv_control <= `DNVM_RST_BYTE;
      end else begin
         nv_data_byte <= data_d;
         nv_control <= ctrl_d;
      end
   end

   // Completion flag and busy indication; a set beats an acknowledge in one cycle.
   always @(posedge core_clk) begin
      if (reset) begin
         nv_done_flag <= `DNVM_RST_BIT;
         busy <= `DNVM_RST_BIT;
      end else begin
         nv_done_flag <= done_d;
         busy <= busy_d;
      end
   end

   // Sequencer state, timers and tag buffer.
   always @(posedge core_clk) begin
      if (reset) begin
         state_q <= S_IDLE;
         tmr_q <= `DNVM_TMR_ZERO;
         rcnt_q <= `DNVM_READ_IDLE;
         tag_q <= {`DNVM_PAGE{1'b0}};
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         rcnt_q <= rcnt_d;
         tag_q <= tag_d;
      end
   end
endmodule // dnvm_sequencer
`default_nettype wire

// file: shared/dnvm_defs.vh
/*
 Constants of the data non-volatile memory access sequencer.
 Assumes a 40 MHz core clock; included by bare name.
*/
`ifndef DNVM_DEFS_VH
`define DNVM_DEFS_VH
`define DNVM_CLK_KHZ 40000
`define DNVM_T_WIPE_LO_US 3200
`define DNVM_T_WIPE_HI_US 3700
`define DNVM_T_WR_LO_US 2200
`define DNVM_T_WR_HI_US 3000
`define DNVM_CYC(us) (((us) * `DNVM_CLK_KHZ) / 1000)
`define DNVM_DEPTH 512
`define DNVM_PAGE 16
`define DNVM_OFS_MAX 4'hf
`define DNVM_ERASED 8'h00
`define DNVM_READ_CYC 2'h2
`define DNVM_READ_STEP 2'h1
`define DNVM_READ_LAST 2'h1
`define DNVM_READ_IDLE 2'h0
`define DNVM_TMR_STEP 32'h0000_0001
`define DNVM_TMR_LAST 32'h0000_0001
`define DNVM_TMR_ZERO 32'h0000_0000
`define DNVM_RST_BYTE 8'h00
`define DNVM_RST_BIT 1'b0
`define DNVM_B_GO_F 0
`define DNVM_B_PM_F 1
`define DNVM_B_GO_P 2
`define DNVM_B_PM_P 3
`define DNVM_B_MODE 4
`define DNVM_B_GO_W 5
`define DNVM_B_PM_W 6
`define DNVM_B_TSEL 7
`endif
